// ==== hdl/pfp_defs.vh ====
// Purpose: constants for the protect, fault and preset controller
// Assumes: 200 MHz hclk, settings and measurements in 0.1 unit steps
// Notes:   byte offsets of the AHB-Lite register words
`ifndef PFP_DEFS_VH
`define PFP_DEFS_VH

`define PFP_CLK_MHZ    200
`define PFP_DEB_MS     10
`define PFP_HOLD_MS    3000
`define PFP_BOOT_MS    500
`define PFP_FLASH_MS   250
`define PFP_BEEP_MS    100
`define PFP_OP125_MS   300
`define PFP_OP110_MS   1000

`define PFP_A_CTRL     6'h00
`define PFP_A_SETV     6'h04
`define PFP_A_SETF     6'h08
`define PFP_A_SETI     6'h0C
`define PFP_A_LIMLO    6'h10
`define PFP_A_RATI     6'h14
`define PFP_A_RATBUS   6'h18
`define PFP_A_RATP     6'h1C
`define PFP_A_STAT     6'h20
`define PFP_A_CAPT     6'h24

`define PFP_RST_RATI   16'h0320
`define PFP_RST_RATBUS 16'h0FA0
`define PFP_RST_RATP   16'h0FA0

// margins in 0.1 V
`define PFP_MARG_LO    16'h0032
`define PFP_MARG_HI    16'h0064

// percent checks as ratios of small integers
`define PFP_K10        8'h0A
`define PFP_K11        8'h0B
`define PFP_K8         8'h08
`define PFP_K12        8'h0C
`define PFP_K100       8'h64
`define PFP_K125       8'h7D
`define PFP_K110       8'h6E

`define PFP_F_NONE     4'h0
`define PFP_F_START    4'h1
`define PFP_F_OC       4'h2
`define PFP_F_HIA      4'h3
`define PFP_F_LOA      4'h4
`define PFP_F_LOBUS    4'h5
`define PFP_F_HIBUS    4'h6
`define PFP_F_LINE     4'h7
`define PFP_F_FUSE     4'h8
`define PFP_F_IGBT     4'h9
`define PFP_F_TEMP     4'hA
`define PFP_F_OV       4'hB
`define PFP_F_UV       4'hC
`define PFP_F_OP       4'hD

`endif

// ==== hdl/pfp_ctrl.v ====
// Purpose: preset store and recall, fault latch, lamps and alarm
// Assumes: bus and sensing inputs synchronous to hclk, comparator values in 0.1 units
// Notes:   registers reached over AHB-Lite, zero wait states
`timescale 1ns/1ps
`include "pfp_defs.vh"

module pfp_ctrl #(
	parameter [31:0] DEB_CYC   = `PFP_DEB_MS * `PFP_CLK_MHZ * 1000,
	parameter [31:0] HOLD_CYC  = `PFP_HOLD_MS * `PFP_CLK_MHZ * 1000,
	parameter [31:0] BOOT_CYC  = `PFP_BOOT_MS * `PFP_CLK_MHZ * 1000,
	parameter [31:0] FLASH_CYC = `PFP_FLASH_MS * `PFP_CLK_MHZ * 1000,
	parameter [31:0] BEEP_CYC  = `PFP_BEEP_MS * `PFP_CLK_MHZ * 1000,
	parameter [31:0] OP125_CYC = `PFP_OP125_MS * `PFP_CLK_MHZ * 1000,
	parameter [31:0] OP110_CYC = `PFP_OP110_MS * `PFP_CLK_MHZ * 1000
) (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// front panel buttons
	input  wire [2:0]  preset_btn,
	input  wire        out_btn,
	// remote contacts
	input  wire        rem_sel1,
	input  wire        rem_sel2,
	input  wire        rem_onoff,
	// sensing
	input  wire        inv_ready,
	input  wire        line_ok,
	input  wire        fuse_open,
	input  wire        igbt_ovl,
	input  wire        over_temp,
	input  wire [15:0] meas_v,
	input  wire [15:0] meas_i,
	input  wire [15:0] meas_p,
	input  wire [15:0] bus_v,
	// power stage
	output reg         out_en_r,
	output reg         ramp_r,
	// indicators
	output reg  [2:0]  preset_lamp_r,
	output reg         out_lamp_r,
	output reg         fail_lamp_r,
	output reg         protect_lamp_r,
	output reg         buzzer_r,
	output reg  [3:0]  freq_code_r,
	output reg         volt_fail_r,
	output reg         remote_note_r
);

	localparam [6:0] S_BOOT  = 7'h01;
	localparam [6:0] S_STBY  = 7'h02;
	localparam [6:0] S_HOLD  = 7'h04;
	localparam [6:0] S_ON    = 7'h08;
	localparam [6:0] S_REOFF = 7'h10;
	localparam [6:0] S_FAULT = 7'h20;
	localparam [6:0] S_FAIL  = 7'h40;

	wire [6:0] raw_w = {rem_onoff, rem_sel2, rem_sel1, out_btn, preset_btn};
	wire [6:0] db_w;
	reg  [6:0] db_q_r;
	wire [6:0] rise_w = db_w & ~db_q_r;
	wire [6:0] fall_w = ~db_w & db_q_r;

	// two-flop sync then stable-count filter per input
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1)
		begin : g_deb
			reg        s1_r;
			reg        s2_r;
			reg        db_r;
			reg [31:0] cnt_r;
			always @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					s1_r  <= 1'b0;
					s2_r  <= 1'b0;
					db_r  <= 1'b0;
					cnt_r <= 32'h0;
				end
				else
				begin
					s1_r <= raw_w[gi];
					s2_r <= s1_r;
					if (s2_r == db_r)
						cnt_r <= 32'h0;
					else if (cnt_r >= DEB_CYC - 32'h1)
					begin
						cnt_r <= 32'h0;
						db_r  <= s2_r;
					end
					else
						cnt_r <= cnt_r + 32'h1;
				end
			end
			assign db_w[gi] = db_r;
		end
	endgenerate

	// registers
	reg        remote_r;
	reg        hirange_r;
	reg [15:0] disp_v_r;
	reg [15:0] disp_f_r;
	reg [15:0] disp_i_r;
	reg [15:0] lim_lo_r;
	reg [15:0] rat_i_r;
	reg [15:0] rat_bus_r;
	reg [15:0] rat_p_r;
	reg [15:0] cap_v_r;
	reg [15:0] cap_i_r;
	reg [47:0] preset_r [0:2];

	reg [6:0]  st_r;
	reg [1:0]  sel_r;
	reg [31:0] tmr_r;
	reg [3:0]  code_r;
	reg        alarm_r;
	reg        drop_r;
	reg [1:0]  racc_r;
	reg        reject_r;
	reg [31:0] op1_r;
	reg [31:0] op2_r;

	// fault detection
	wire [23:0] i10  = {8'h0, meas_i} * {16'h0, `PFP_K10};
	wire [23:0] b10  = {8'h0, bus_v} * {16'h0, `PFP_K10};
	wire [23:0] p100 = {8'h0, meas_p} * {16'h0, `PFP_K100};
	wire [23:0] i_oc = {8'h0, rat_i_r} * {16'h0, `PFP_K11};
	wire [23:0] b_lo = {8'h0, rat_bus_r} * {16'h0, `PFP_K8};
	wire [23:0] b_hi = {8'h0, rat_bus_r} * {16'h0, `PFP_K12};
	wire [23:0] p125 = {8'h0, rat_p_r} * {16'h0, `PFP_K125};
	wire [23:0] p110 = {8'h0, rat_p_r} * {16'h0, `PFP_K110};
	wire [16:0] marg = {1'b0, (hirange_r ? `PFP_MARG_HI : `PFP_MARG_LO)};
	wire [16:0] vhi  = {1'b0, disp_v_r} + marg;
	wire [16:0] vlo  = {1'b0, meas_v} + marg;
	wire        on_w = (st_r == S_ON);
	wire        op125 = p100 > p125;
	wire        op110 = p100 > p110;
	reg  [3:0]  flt;

	always @*
	begin
		flt = `PFP_F_NONE;
		if (fuse_open)
			flt = `PFP_F_FUSE;
		else if (igbt_ovl)
			flt = `PFP_F_IGBT;
		else if (over_temp)
			flt = `PFP_F_TEMP;
		else if (drop_r && line_ok)
			flt = `PFP_F_LINE;
		else if (b10 < b_lo)
			flt = `PFP_F_LOBUS;
		else if (b10 > b_hi)
			flt = `PFP_F_HIBUS;
		else if (on_w)
		begin
			if (i10 > i_oc)
				flt = `PFP_F_OC;
			else if (meas_i > disp_i_r)
				flt = `PFP_F_HIA;
			else if (meas_i < lim_lo_r)
				flt = `PFP_F_LOA;
			else if ({1'b0, meas_v} > vhi)
				flt = `PFP_F_OV;
			else if (vlo < {1'b0, disp_v_r})
				flt = `PFP_F_UV;
			else if ((op125 && op1_r >= OP125_CYC - 32'h1) ||
				(op110 && op2_r >= OP110_CYC - 32'h1))
				flt = `PFP_F_OP;
		end
	end

	// overpower persistence timers and line drop latch
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			op1_r  <= 32'h0;
			op2_r  <= 32'h0;
			drop_r <= 1'b0;
		end
		else
		begin
			op1_r <= (on_w && op125) ? op1_r + 32'h1 : 32'h0;
			op2_r <= (on_w && op110) ? op2_r + 32'h1 : 32'h0;
			if (!line_ok)
				drop_r <= 1'b1;
			else if (st_r == S_FAULT && code_r == `PFP_F_LINE)
				drop_r <= 1'b0;
		end
	end

	// ahb-lite slave
	reg        dph_r;
	reg        dwr_r;
	reg [5:0]  dad_r;
	wire       aph = hsel & htrans[1] & hready;
	wire       wr_ok = dph_r & dwr_r;
	wire       idle_w = (st_r == S_STBY);
	reg [31:0] rd;

	always @*
	begin
		case (haddr[5:0])
		`PFP_A_CTRL:   rd = {30'h0, hirange_r, remote_r};
		`PFP_A_SETV:   rd = {16'h0, disp_v_r};
		`PFP_A_SETF:   rd = {16'h0, disp_f_r};
		`PFP_A_SETI:   rd = {16'h0, disp_i_r};
		`PFP_A_LIMLO:  rd = {16'h0, lim_lo_r};
		`PFP_A_RATI:   rd = {16'h0, rat_i_r};
		`PFP_A_RATBUS: rd = {16'h0, rat_bus_r};
		`PFP_A_RATP:   rd = {16'h0, rat_p_r};
		`PFP_A_STAT:   rd = {18'h0, alarm_r, 1'b0, code_r, 1'b0, st_r};
		`PFP_A_CAPT:   rd = {cap_i_r, cap_v_r};
		default:       rd = 32'h0;
		endcase
		if (haddr[31:6] != 26'h0)
			rd = 32'h0;
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_r     <= 1'b0;
			dwr_r     <= 1'b0;
			dad_r     <= 6'h0;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			remote_r  <= 1'b0;
			hirange_r <= 1'b0;
			lim_lo_r  <= 16'h0;
			rat_i_r   <= `PFP_RST_RATI;
			rat_bus_r <= `PFP_RST_RATBUS;
			rat_p_r   <= `PFP_RST_RATP;
		end
		else
		begin
			dph_r <= aph;
			dwr_r <= hwrite;
			dad_r <= haddr[31:6] == 26'h0 ? haddr[5:0] : 6'h3C;
			if (aph && !hwrite)
				hrdata <= rd;
			if (wr_ok)
			begin
				case (dad_r)
				`PFP_A_CTRL:
				begin
					remote_r  <= hwdata[0];
					hirange_r <= hwdata[1];
				end
				`PFP_A_LIMLO:  lim_lo_r <= hwdata[15:0];
				`PFP_A_RATI:   rat_i_r <= hwdata[15:0];
				`PFP_A_RATBUS: rat_bus_r <= hwdata[15:0];
				`PFP_A_RATP:   rat_p_r <= hwdata[15:0];
				default:       ;
				endcase
			end
		end
	end

	// remote preset code: line one, line two, or both
	wire [1:0] rcode = racc_r - 2'h1;
	wire       rrel = (racc_r != 2'h0) && !db_w[4] && !db_w[5];
	wire       pnl_any = |rise_w[3:0];
	wire [1:0] pk = rise_w[0] ? 2'h0 : rise_w[1] ? 2'h1 : 2'h2;
	wire [1:0] fk = fall_w[0] ? 2'h0 : fall_w[1] ? 2'h1 : 2'h2;

	// main sequencer
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r     <= S_BOOT;
			sel_r    <= 2'h0;
			tmr_r    <= 32'h0;
			code_r   <= `PFP_F_NONE;
			alarm_r  <= 1'b0;
			racc_r   <= 2'h0;
			reject_r <= 1'b0;
			disp_v_r <= 16'h0;
			disp_f_r <= 16'h0;
			disp_i_r <= 16'h0;
			cap_v_r  <= 16'h0;
			cap_i_r  <= 16'h0;
			preset_r[0] <= 48'h0;
			preset_r[1] <= 48'h0;
			preset_r[2] <= 48'h0;
			db_q_r   <= 7'h0;
		end
		else
		begin
			db_q_r   <= db_w;
			reject_r <= 1'b0;
			if (db_w[4] || db_w[5])
				racc_r <= racc_r | {db_w[5], db_w[4]};
			else
				racc_r <= 2'h0;
			if (wr_ok && idle_w)
			begin
				if (dad_r == `PFP_A_SETV)
					disp_v_r <= hwdata[15:0];
				if (dad_r == `PFP_A_SETF)
					disp_f_r <= hwdata[15:0];
				if (dad_r == `PFP_A_SETI)
					disp_i_r <= hwdata[15:0];
			end
			case (st_r)
			S_BOOT:
				if (inv_ready)
					st_r <= S_STBY;
				else if (tmr_r >= BOOT_CYC - 32'h1)
				begin
					st_r    <= S_FAIL;
					code_r  <= `PFP_F_START;
					alarm_r <= 1'b1;
				end
				else
					tmr_r <= tmr_r + 32'h1;
			S_FAIL:
				st_r <= S_FAIL;
			S_FAULT:
				// later faults never replace the held code
				if (rise_w[3] || (remote_r && rise_w[6]))
				begin
					if (alarm_r)
						alarm_r <= 1'b0;
					else
					begin
						code_r <= `PFP_F_NONE;
						st_r   <= S_STBY;
					end
				end
			default:
				if (flt != `PFP_F_NONE)
				begin
					st_r    <= S_FAULT;
					code_r  <= flt;
					alarm_r <= 1'b1;
					cap_v_r <= meas_v;
					cap_i_r <= meas_i;
				end
				else
				begin
					case (st_r)
					S_STBY:
						if (remote_r && pnl_any)
							reject_r <= 1'b1;
						else if (remote_r && rise_w[6])
							st_r <= S_ON;
						else if (!remote_r && rise_w[3])
							st_r <= S_ON;
						else if (!remote_r && |rise_w[2:0])
						begin
							st_r  <= S_HOLD;
							sel_r <= pk;
							tmr_r <= 32'h0;
						end
					S_HOLD:
						if (db_w[sel_r])
						begin
							if (tmr_r >= HOLD_CYC - 32'h1)
							begin
								preset_r[sel_r] <= {disp_v_r,
									disp_f_r, disp_i_r};
								st_r <= S_STBY;
							end
							else
								tmr_r <= tmr_r + 32'h1;
						end
						else
						begin
							// early release recalls, store untouched
							{disp_v_r, disp_f_r, disp_i_r}
								<= preset_r[sel_r];
							st_r <= S_STBY;
						end
					S_ON:
						if (remote_r && pnl_any)
						begin
							reject_r <= 1'b1;
							st_r     <= S_STBY;
						end
						else if (remote_r && fall_w[6])
							st_r <= S_STBY;
						else if (remote_r && rrel)
						begin
							{disp_v_r, disp_f_r, disp_i_r}
								<= preset_r[rcode];
							st_r <= S_REOFF;
						end
						else if (!remote_r && rise_w[3])
							st_r <= S_STBY;
						else if (!remote_r && |fall_w[2:0])
						begin
							{disp_v_r, disp_f_r, disp_i_r}
								<= preset_r[fk];
							st_r <= S_REOFF;
						end
					S_REOFF:
						st_r <= S_ON;
					default:
						st_r <= S_STBY;
					endcase
				end
			endcase
		end
	end

	// flash clock and double beep
	reg [31:0] fl_cnt_r;
	reg        flash_r;
	reg [31:0] bp_cnt_r;
	reg [2:0]  bp_ph_r;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fl_cnt_r <= 32'h0;
			flash_r  <= 1'b0;
			bp_cnt_r <= 32'h0;
			bp_ph_r  <= 3'h0;
		end
		else
		begin
			if (fl_cnt_r >= FLASH_CYC - 32'h1)
			begin
				fl_cnt_r <= 32'h0;
				flash_r  <= ~flash_r;
			end
			else
				fl_cnt_r <= fl_cnt_r + 32'h1;
			if (reject_r)
			begin
				bp_ph_r  <= 3'h4;
				bp_cnt_r <= 32'h0;
			end
			else if (bp_ph_r != 3'h0)
			begin
				if (bp_cnt_r >= BEEP_CYC - 32'h1)
				begin
					bp_cnt_r <= 32'h0;
					bp_ph_r  <= bp_ph_r - 3'h1;
				end
				else
					bp_cnt_r <= bp_cnt_r + 32'h1;
			end
		end
	end

	// registered outputs
	wire flt_w = (st_r == S_FAULT);

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			out_en_r       <= 1'b0;
			ramp_r         <= 1'b0;
			preset_lamp_r  <= 3'h0;
			out_lamp_r     <= 1'b0;
			fail_lamp_r    <= 1'b0;
			protect_lamp_r <= 1'b0;
			buzzer_r       <= 1'b0;
			freq_code_r    <= 4'h0;
			volt_fail_r    <= 1'b0;
			remote_note_r  <= 1'b0;
		end
		else
		begin
			out_en_r <= on_w;
			ramp_r   <= on_w && !out_en_r;
			preset_lamp_r <= (st_r == S_HOLD && flash_r) ?
				(3'h1 << sel_r) : 3'h0;
			out_lamp_r     <= on_w | (flt_w & flash_r);
			fail_lamp_r    <= flt_w & flash_r;
			protect_lamp_r <= flt_w;
			buzzer_r <= alarm_r | (bp_ph_r[0] == 1'b0 &&
				bp_ph_r != 3'h0);
			freq_code_r    <= flt_w ? code_r : `PFP_F_NONE;
			volt_fail_r    <= (st_r == S_FAIL);
			remote_note_r  <= (bp_ph_r != 3'h0);
		end
	end

endmodule

// ==== testbench/pfp_ctrl_chk.sv ====
// Purpose: port-level assertions for pfp_ctrl
// Assumes: one hclk domain, asynchronous active-low hresetn
// Notes:   bound into every pfp_ctrl instance
`timescale 1ns/1ps
module pfp_chk (
	// clock and reset
	input wire       hclk,
	input wire       hresetn,
	// watched outputs
	input wire       hreadyout,
	input wire       hresp,
	input wire       out_en_r,
	input wire       ramp_r,
	input wire [2:0] preset_lamp_r,
	input wire       protect_lamp_r,
	input wire       buzzer_r,
	input wire [3:0] freq_code_r,
	input wire       volt_fail_r
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus wait or error response");
	a_fault_off: assert property (
		freq_code_r != 4'h0 |-> !out_en_r && protect_lamp_r)
		else $error("output on or lamp dark in fault");
	a_fault_alarm: assert property (
		$rose(freq_code_r != 4'h0) |-> buzzer_r)
		else $error("no alarm with new fault code");
	a_code_kept: assert property (
		$past(freq_code_r) != 4'h0 && freq_code_r != 4'h0
		|-> freq_code_r == $past(freq_code_r))
		else $error("fault code overwritten");
	a_ramp_pulse: assert property (ramp_r |=> !ramp_r)
		else $error("ramp pulse longer than one cycle");
	a_ramp_on: assert property (ramp_r |-> ##[0:1] out_en_r)
		else $error("ramp without output on");
	a_fail_lock: assert property (
		volt_fail_r |=> volt_fail_r && buzzer_r && !out_en_r)
		else $error("startup failure not locked");
	a_fail_nocode: assert property (
		volt_fail_r |-> freq_code_r == 4'h0)
		else $error("startup failure on frequency display");
	a_slot_single: assert property ($onehot0(preset_lamp_r))
		else $error("more than one slot lamp");
	a_store_idle: assert property (
		preset_lamp_r != 3'h0 |-> !out_en_r)
		else $error("store hold while output on");
endmodule

bind pfp_ctrl pfp_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp,
	.out_en_r, .ramp_r, .preset_lamp_r, .protect_lamp_r, .buzzer_r,
	.freq_code_r, .volt_fail_r);

// ==== testbench/pfp_panel.sv ====
// Purpose: front panel buttons and remote contact closures
// Assumes: contacts read 1 while closed, 0 while open
// Notes:   every closure outlasts sync and debounce, then settles
`timescale 1ns/1ps
module pfp_panel (
	// clock
	input  wire       hclk,
	// panel buttons
	output wire [2:0] preset_btn,
	output wire       out_btn,
	// remote contacts
	output reg        rem_sel1,
	output reg        rem_sel2,
	output reg        rem_onoff
);
	reg [3:0] btn_r;

	assign preset_btn = btn_r[2:0];
	assign out_btn    = btn_r[3];

	initial
	begin
		btn_r     = 4'h0;
		rem_sel1  = 1'b0;
		rem_sel2  = 1'b0;
		rem_onoff = 1'b0;
	end

	// button k: 0..2 presets, 3 output/reset
	task press(input integer k, input integer n);
	begin
		@(posedge hclk);
		btn_r[k] <= 1'b1;
		repeat (n) @(posedge hclk);
		btn_r[k] <= 1'b0;
		repeat (16) @(posedge hclk);
	end
	endtask

	// momentary closure; slot three closes both lines
	task pick(input [1:0] k);
	begin
		@(posedge hclk);
		rem_sel1 <= k[0];
		rem_sel2 <= k[1];
		repeat (12) @(posedge hclk);
		rem_sel1 <= 1'b0;
		rem_sel2 <= 1'b0;
		repeat (16) @(posedge hclk);
	end
	endtask

	task onoff(input v);
	begin
		@(posedge hclk);
		rem_onoff <= v;
		repeat (16) @(posedge hclk);
	end
	endtask
endmodule

// ==== testbench/tb_pfp_ctrl.sv ====
// Purpose: self-checking bench for pfp_ctrl
// Assumes: shortened timing parameters, zero-wait bus slave
// Notes:   slots share voltage and current, differ in frequency
`timescale 1ns/1ps
module tb_pfp_ctrl;
	reg         hclk, hresetn, hsel, hwrite;
	reg  [31:0] haddr, hwdata, rd;
	reg  [1:0]  htrans;
	reg  [2:0]  hsize;
	reg         inv_ready, line_ok, fuse_open, igbt_ovl, over_temp;
	reg  [15:0] meas_v, meas_i, meas_p, bus_v;
	wire [31:0] hrdata;
	wire        hreadyout, hresp, hready, out_btn;
	wire        rem_sel1, rem_sel2, rem_onoff, out_en_r, ramp_r;
	wire [2:0]  preset_btn, preset_lamp_r;
	wire        out_lamp_r, fail_lamp_r, protect_lamp_r;
	wire        buzzer_r, volt_fail_r, remote_note_r;
	wire [3:0]  freq_code_r;
	integer     bad_count, check_count, cyc, i, k, n, j;
	integer     n_ramp, n_fall, n_buz, n_fail, n_olmp, n_lamp, n_note;

	assign hready = hreadyout;

	pfp_ctrl #(.DEB_CYC(4), .HOLD_CYC(50), .BOOT_CYC(20), .FLASH_CYC(8),
		.BEEP_CYC(6), .OP125_CYC(10), .OP110_CYC(30)) dut (.hclk,
		.hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
		.hwdata, .hrdata, .hreadyout, .hresp, .preset_btn, .out_btn,
		.rem_sel1, .rem_sel2, .rem_onoff, .inv_ready, .line_ok,
		.fuse_open, .igbt_ovl, .over_temp, .meas_v, .meas_i, .meas_p,
		.bus_v, .out_en_r, .ramp_r, .preset_lamp_r, .out_lamp_r,
		.fail_lamp_r, .protect_lamp_r, .buzzer_r, .freq_code_r,
		.volt_fail_r, .remote_note_r);

	pfp_panel pnl (.hclk, .preset_btn, .out_btn, .rem_sel1, .rem_sel2,
		.rem_onoff);

	always #2.5 hclk = ~hclk;

	task give_verdict;
	begin
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask

	always @(posedge hclk)
	begin
		cyc    <= cyc + 1;
		n_ramp <= n_ramp + ramp_r;
		n_fall <= n_fall + $fell(out_en_r);
		n_buz  <= n_buz + $rose(buzzer_r);
		n_fail <= n_fail + $rose(fail_lamp_r);
		n_olmp <= n_olmp + $rose(out_lamp_r);
		n_lamp <= n_lamp + $rose(|preset_lamp_r);
		n_note <= n_note + $rose(remote_note_r);
		if (cyc == 40000)
		begin
			bad_count = bad_count + 1;
			give_verdict;
		end
	end

	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
	begin
		check_count = check_count + 1;
		if (g !== e)
		begin
			bad_count = bad_count + 1;
			$display("ERROR %0s exp %h got %h", nm, e, g);
		end
	end
	endtask

	// one single word transfer; read data taken at the data phase edge
	task bus(input w, input [31:0] a, input [31:0] d);
	begin
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		hsize  <= 3'h2;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	end
	endtask

	task rdc(input [31:0] a, input [31:0] e, input [63:0] nm);
	begin
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	end
	endtask

	initial
	begin
		{hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = 0;
		{bad_count, check_count, cyc, n_ramp, n_fall} = 0;
		{n_buz, n_fail, n_olmp, n_lamp, n_note} = 0;
		hsize = 3'h2;
		{inv_ready, line_ok, fuse_open, igbt_ovl, over_temp} = 5'h18;
		{meas_v, meas_i, meas_p, bus_v} = {16'h64, 16'h100, 16'h0, 16'hFA0};
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (40) @(posedge hclk);
		rdc(32'h20, 32'h2, "stat");
		rdc(32'h14, 32'h320, "rati");
		rdc(32'h18, 32'hFA0, "ratbus");
		rdc(32'h1C, 32'hFA0, "ratp");
		rdc(32'h30, 32'h0, "unmap");
		bus(1'b1, 32'h20, 32'h7F);
		rdc(32'h20, 32'h2, "stat_ro");
		bus(1'b1, 32'h10, 32'h50);
		for (i = 0; i < 3; i = i + 1)
		begin
			bus(1'b1, 32'h4, 32'h64);
			bus(1'b1, 32'h8, 32'h1F4 + i * 100);
			bus(1'b1, 32'hC, 32'h200);
			n = n_lamp;
			pnl.press(i, 80);
			chk("flash", 1, n_lamp - n > 1);
			chk("lamp", 0, preset_lamp_r);
		end
		// early release recalls and leaves the slot alone
		bus(1'b1, 32'h8, 32'h300);
		pnl.press(0, 12);
		rdc(32'h8, 32'h1F4, "recall1");
		chk("stby", 0, out_en_r);
		pnl.press(3, 12);
		chk("on", 1, out_en_r);
		n = n_fall;
		k = n_ramp;
		pnl.press(1, 12);
		chk("dip", n + 1, n_fall);
		chk("ramp", k + 1, n_ramp);
		chk("on2", 1, out_en_r);
		rdc(32'h8, 32'h258, "recall2");
		pnl.press(3, 12);
		chk("off", 0, out_en_r);
		for (i = 0; i < 13; i = i + 1)
		begin
			pnl.press(3, 12);
			if (i == 9)
			begin
				bus(1'b1, 32'h0, 32'h2);
				meas_v <= 16'h00C8;
				repeat (20) @(posedge hclk);
				chk("hi_marg", 0, freq_code_r);
			end
			if (i == 10)
				bus(1'b1, 32'h0, 32'h0);
			n = n_fail;
			j = n_olmp;
			case (i)
			0: meas_i <= 16'h0371;
			1: meas_i <= 16'h0201;
			2: meas_i <= 16'h004F;
			3: bus_v <= 16'h0C7F;
			4: bus_v <= 16'h12C1;
			5: line_ok <= 1'b0;
			6: fuse_open <= 1'b1;
			7: igbt_ovl <= 1'b1;
			8: over_temp <= 1'b1;
			9: meas_v <= 16'h00C9;
			10: meas_v <= 16'h0031;
			11: meas_p <= 16'h1389;
			default: meas_p <= 16'h1131;
			endcase
			repeat (40) @(posedge hclk);
			{meas_v, meas_i, meas_p, bus_v} <= {16'h64, 16'h100, 16'h0,
				16'hFA0};
			{line_ok, fuse_open, igbt_ovl, over_temp} <= 4'h8;
			for (k = 0; k < 20 && freq_code_r === 4'h0; k = k + 1)
				@(posedge hclk);
			chk("code", (i < 12) ? i + 2 : 13, freq_code_r);
			chk("f_off", 0, out_en_r);
			chk("alarm", 1, buzzer_r);
			chk("prot", 1, protect_lamp_r);
			if (i == 0)
				rdc(32'h24, 32'h03710064, "capt");
			@(posedge hclk);
			fuse_open <= 1'b1;
			repeat (5) @(posedge hclk);
			fuse_open <= 1'b0;
			chk("kept", (i < 12) ? i + 2 : 13, freq_code_r);
			pnl.press(3, 12);
			chk("silent", 0, buzzer_r);
			chk("held", (i < 12) ? i + 2 : 13, freq_code_r);
			chk("blink", 1, n_fail - n > 1 && n_olmp - j > 1);
			pnl.press(3, 12);
			chk("clear", 0, freq_code_r);
			rdc(32'h20, 32'h2, "stat_clr");
		end
		bus(1'b1, 32'h0, 32'h1);
		n = n_buz;
		k = n_note;
		pnl.press(3, 12);
		repeat (40) @(posedge hclk);
		chk("beeps", n + 2, n_buz);
		chk("note", k + 1, n_note);
		chk("r_stby", 0, out_en_r);
		pnl.onoff(1'b1);
		chk("r_on", 1, out_en_r);
		n = n_fall;
		pnl.pick(2'h3);
		chk("r_dip", n + 1, n_fall);
		rdc(32'h8, 32'h2BC, "recall3");
		pnl.pick(2'h1);
		rdc(32'h8, 32'h1F4, "recall1r");
		pnl.onoff(1'b0);
		chk("r_stop", 0, out_en_r);
		pnl.onoff(1'b1);
		k = n_note;
		pnl.press(0, 12);
		chk("r_rej", 0, out_en_r);
		chk("r_note2", k + 1, n_note);
		pnl.onoff(1'b0);
		inv_ready <= 1'b0;
		hresetn   <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (40) @(posedge hclk);
		chk("vfail", 1, volt_fail_r);
		chk("valarm", 1, buzzer_r);
		pnl.press(3, 12);
		chk("locked", 0, out_en_r);
		rdc(32'h20, 32'h2140, "fstat");
		give_verdict;
	end
endmodule
